// ---- bench/ocs_top_properties.sv ----
`timescale 1ns/1ns
module ocs_top_properties (
	input logic sys_clk, rst_b, psel, penable, pwrite, pready,
	input logic [7:0] paddr,
	input logic [31:0] pwdata, prdata,
	input logic crystal_osc_control_run, crystal_osc_control_crystal_mode, crystal_osc_control_auto_gain, crystal_output_pad_gpio_free,
	input logic [2:0] crystal_osc_control_gain
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	wire acc = psel && penable && !pready;
	wire cw = acc && pwrite && paddr == ocs_pkg::ADDR_XCTRL;
	AST_PULSE: assert property (pready |=> !pready) else $error("long pready");
	AST_ANSWER: assert property (acc |=> pready) else $error("late pready");
	AST_PADS: assert property (crystal_osc_control_crystal_mode != crystal_output_pad_gpio_free) else $error("pad select");
	AST_GAIN_CAP: assert property (crystal_osc_control_gain <= 3'h4) else $error("reserved gain");
	AST_GAIN_HOLD: assert property (crystal_osc_control_auto_gain && $past(crystal_osc_control_auto_gain) |-> $stable(crystal_osc_control_gain))
		else $error("gain moved");
	AST_CTRL_OUT: assert property (cw |=> crystal_osc_control_auto_gain == $past(pwdata[11])) else $error("auto gain");
	AST_OFF: assert property (cw && !pwdata[1] |-> ##[1:3] !crystal_osc_control_run) else $error("still running");
	AST_RDY_RUN: assert property (pready && !pwrite && paddr == ocs_pkg::ADDR_STATUS && prdata[0] |-> $past(crystal_osc_control_run))
		else $error("ready while stopped");
endmodule
bind ocs_top ocs_top_properties CHK (.*);

// ---- bench/ocs_top_tb.sv ----
`timescale 1ns/1ns
module ocs_top_tb;
	logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, ulp32k_clk_async, crystal_osc_control_clk_async;
	logic periph_clk_req_async, standby_sleep_async, crystal_osc_control_run, crystal_osc_control_crystal_mode, crystal_osc_control_auto_gain;
	logic crystal_output_pad_gpio_free, irq;
	logic [2:0] crystal_osc_control_gain;
	logic [7:0] paddr;
	logic [10:0] src_status_async;
	logic [31:0] pwdata, prdata;
	logic [31:0] expq[$];
	int bad_count = 0, checked = 0, seed = 51;
	localparam logic [7:0] XC = ocs_pkg::ADDR_XCTRL;
	localparam logic [7:0] ST = ocs_pkg::ADDR_STATUS;
	ocs_top DUT (.*);
	ocs_xtal_model XM (.run(crystal_osc_control_run), .xclk(crystal_osc_control_clk_async));
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial begin
		ulp32k_clk_async = 1'b0;
		forever #500 ulp32k_clk_async = ~ulp32k_clk_async;
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, s, e);
		end
	endtask
	task complete_run;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task ap(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk) penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		expq.push_back(e);
		ap(1'b0, a, 32'h0000_0000);
	endtask
	task wc(input logic [15:0] d);
		ap(1'b1, XC, {16'h0000, d});
	endtask
	function logic [31:0] st(input logic b);
		return {20'h0_0000, src_status_async, b};
	endfunction
	always @(posedge sys_clk)
		if (pready === 1'b1 && pwrite === 1'b0 && expq.size() > 0)
			chk(prdata, expq.pop_front());
	initial begin
		#2000000;
		bad_count++;
		complete_run();
	end
	initial begin
		{rst_b, psel, penable, pwrite, periph_clk_req_async, standby_sleep_async} = '0;
		{paddr, pwdata} = '0;
		src_status_async = 11'($random(seed)) & 11'h3FF;
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		chk(irq, 1'b0);
		chk(crystal_output_pad_gpio_free, 1'b1);
		chk(pslverr, 1'b0);
		rd(XC, 32'h0000_0080);
		ap(1'b1, ST, 32'hFFFF_FFFF);
		rd(ST, st(1'b0));
		rd(ocs_pkg::ADDR_MODE, 32'h0000_0000);
		$display("t1 end");
		wc(16'h2706);
		rd(XC, 32'h0000_2706);
		chk(crystal_osc_control_gain, 3'h4);
		chk(crystal_output_pad_gpio_free, 1'b0);
		chk(crystal_osc_control_crystal_mode, 1'b1);
		rd(ST, st(1'b0));
		repeat (80) @(posedge sys_clk);
		rd(ST, st(1'b1));
		wc(16'h2F06);
		wc(16'h2906);
		chk(crystal_osc_control_gain, 3'h4);
		chk(crystal_osc_control_auto_gain, 1'b1);
		wc(16'h2904);
		rd(ST, st(1'b0));
		chk(crystal_osc_control_run, 1'b0);
		$display("t2 end");
		wc(16'h0086);
		chk(crystal_osc_control_run, 1'b0);
		periph_clk_req_async <= 1'b1;
		repeat (5) @(posedge sys_clk);
		chk(crystal_osc_control_run, 1'b1);
		standby_sleep_async <= 1'b1;
		repeat (5) @(posedge sys_clk);
		chk(crystal_osc_control_run, 1'b0);
		wc(16'h00C6);
		chk(crystal_osc_control_run, 1'b1);
		wc(16'h0046);
		periph_clk_req_async <= 1'b0;
		repeat (5) @(posedge sys_clk);
		chk(crystal_osc_control_run, 1'b1);
		$display("t3 end");
		ap(1'b1, ocs_pkg::ADDR_IEN, 32'h0000_0800);
		src_status_async[10] <= 1'b1;
		repeat (6) @(posedge sys_clk);
		chk(irq, 1'b1);
		ap(1'b1, ocs_pkg::ADDR_IFLAG, 32'h0000_0800);
		chk(irq, 1'b0);
		$display("t4 end");
		complete_run();
	end
endmodule

// ---- bench/ocs_xtal_model.sv ----
`timescale 1ns/1ns
module ocs_xtal_model (
	input logic run,
	output logic xclk
);
	// a stopped crystal gives no edges, so the sync delay cannot finish early
	initial xclk = 1'b0;
	always #130 xclk = run ? ~xclk : 1'b0;
endmodule

// ---- common/ocs_pkg.sv ----
package ocs_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_XCTRL = 8'h10;
	localparam logic [7:0] ADDR_IFLAG = 8'h08;
	localparam logic [7:0] ADDR_IEN = 8'h04;
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [15:0] XCTRL_RESET = 16'h0080;
	localparam logic [15:0] XCTRL_MASK = 16'hFFC6;
	localparam int XC_COUNT_SELECT_A_LSB = 12;
	localparam int XC_AGC = 11;
	localparam int XC_GAIN_LSB = 8;
	localparam int XC_RUN_ON_REQUEST = 7;
	localparam int XC_STANDBY = 6;
	localparam int XC_PAD = 2;
	localparam int XC_ENABLE = 1;
	localparam int ST_XRDY = 0;
	localparam int ST_SUPPLY_BUSY = 11;
	localparam int ST_WIDTH = 12;
	localparam logic [1:0] SYNC_CYCLES = 2'h3;
	localparam logic [2:0] GAIN_MAX_CODE = 3'h4;
	localparam int CNT_W = 16;
	typedef enum logic [1:0] {XS_OFF = 2'b00, XS_COUNT = 2'b01, XS_SYNC = 2'b11, XS_READY = 2'b10} ocs_xstate_t;
endpackage

// ---- hdl/ocs_top.sv ----
// Chosen here: register access over APB.
`timescale 1ns/1ns
// How it works
// - status bit 11 shows supply monitor synchronisation still running.
// - status bit 10 shows supply below threshold detected.
// - status bit 9 shows supply monitor ready.
// - status bit 8 shows loop reference clock stopped.
// - status bit 7 shows coarse lock reached.
// - status bit 6 shows fine lock reached.
// - status bit 5 shows loop out of bounds.
// - status bit 4 is 1 when loop synchronisation is complete.
// - status bit 3 shows 8 MHz oscillator ready.
// - status bit 2 shows internal 32 kHz oscillator ready.
// - status bit 1 shows slow crystal ready.
// - status bit 0 shows multipurpose crystal ready.
// - start-up counts 2^code slow-clock ticks, code in bits 15:12.
// - then 3 crystal cycles of synchronisation before ready is set.
// - auto gain bit enables automatic amplitude adjustment.
// - gain field 10:8 selects gain; codes 5 to 7 reserved.
// - gain writes have no effect while auto gain active.
// - on-demand set runs oscillator only while a peripheral requests it.
// - on-demand clear keeps oscillator running while enabled.
// - in standby, oscillator off unless keep-running bit is set.
// - bit 2 selects crystal across pads or external clock on input pad.
// - bit 1 enables the oscillator.
// - rising status bits set write-one-clear flags; enabled flags request interrupt.
module ocs_top (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// asynchronous status from other clock sources
	input wire logic [10:0] src_status_async,
	input wire logic ulp32k_clk_async,
	input wire logic crystal_osc_control_clk_async,
	input wire logic periph_clk_req_async,
	input wire logic standby_sleep_async,
	// oscillator controls and interrupt
	output logic crystal_osc_control_run,
	output logic crystal_osc_control_crystal_mode,
	output logic crystal_osc_control_auto_gain,
	output logic [2:0] crystal_osc_control_gain,
	output logic crystal_output_pad_gpio_free,
	output logic irq
);
	typedef struct packed {
		logic [10:0] src_s1;
		logic [10:0] src_s2;
		logic [2:0] ulp_s;
		logic [2:0] xck_s;
		logic [1:0] req_s;
		logic [1:0] stby_s;
		logic [15:0] xctrl;
		logic [2:0] gain_eff;
		ocs_pkg::ocs_xstate_t xst;
		logic [ocs_pkg::CNT_W-1:0] cnt;
		logic [1:0] sync_cnt;
		logic [ocs_pkg::ST_WIDTH-1:0] status;
		logic [ocs_pkg::ST_WIDTH-1:0] flags;
		logic [ocs_pkg::ST_WIDTH-1:0] ien;
		logic [31:0] rdata;
		logic ready;
		// constant, but kept in a flop so every output comes from a register
		logic slverr;
		logic run;
		// pad and gain-mode outputs follow the control word in the same edge
		logic crystal_mode;
		logic pad_free;
		logic auto_gain;
		logic irq;
	} ocs_state_t;

	ocs_state_t st_reg;
	ocs_state_t st_next;

	function automatic logic [ocs_pkg::CNT_W-1:0] count_select_a_len(input logic [3:0] code);
		count_select_a_len = ocs_pkg::CNT_W'(1) << code;
	endfunction

	function automatic logic rising(input logic [2:0] sh);
		rising = sh[1] & ~sh[2];
	endfunction

	// reserved gain codes are clamped so the oscillator never sees them
	function automatic logic [2:0] clamp_gain(input logic [2:0] code);
		if (code > ocs_pkg::GAIN_MAX_CODE) begin
			clamp_gain = ocs_pkg::GAIN_MAX_CODE;
		end else begin
			clamp_gain = code;
		end
	endfunction

	logic acc_done;
	logic wr;
	logic run_want;
	logic [ocs_pkg::ST_WIDTH-1:0] status_now;
	logic [ocs_pkg::ST_WIDTH-1:0] rise;

	always_comb begin
		st_next = st_reg;
		acc_done = psel & penable & ~st_reg.ready;
		wr = acc_done & pwrite;
		// synchronisers: stage one feeds stage two only
		st_next.src_s1 = src_status_async;
		st_next.src_s2 = st_reg.src_s1;
		st_next.ulp_s = {st_reg.ulp_s[1:0], ulp32k_clk_async};
		st_next.xck_s = {st_reg.xck_s[1:0], crystal_osc_control_clk_async};
		st_next.req_s = {st_reg.req_s[0], periph_clk_req_async};
		st_next.stby_s = {st_reg.stby_s[0], standby_sleep_async};

		if (wr && paddr == ocs_pkg::ADDR_XCTRL) begin
			st_next.xctrl = pwdata[15:0] & ocs_pkg::XCTRL_MASK;
		end
		if (wr && paddr == ocs_pkg::ADDR_IEN) begin
			st_next.ien = pwdata[ocs_pkg::ST_WIDTH-1:0];
		end
		st_next.crystal_mode = st_next.xctrl[ocs_pkg::XC_PAD];
		st_next.pad_free = ~st_next.xctrl[ocs_pkg::XC_PAD];
		st_next.auto_gain = st_next.xctrl[ocs_pkg::XC_AGC];

		// gain field only reaches the oscillator while auto gain is off
		if (!st_reg.xctrl[ocs_pkg::XC_AGC]) begin
			st_next.gain_eff = clamp_gain(st_reg.xctrl[ocs_pkg::XC_GAIN_LSB+:3]);
		end

		run_want = st_reg.xctrl[ocs_pkg::XC_ENABLE]
			& (~st_reg.xctrl[ocs_pkg::XC_RUN_ON_REQUEST] | st_reg.req_s[1])
			& (~st_reg.stby_s[1] | st_reg.xctrl[ocs_pkg::XC_STANDBY]);
		st_next.run = run_want;

		unique case (st_reg.xst)
			ocs_pkg::XS_OFF: begin
				if (run_want) begin
					st_next.xst = ocs_pkg::XS_COUNT;
					st_next.cnt = count_select_a_len(st_reg.xctrl[ocs_pkg::XC_COUNT_SELECT_A_LSB+:4]);
				end
			end
			ocs_pkg::XS_COUNT: begin
				if (rising(st_reg.ulp_s)) begin
					st_next.cnt = st_reg.cnt - ocs_pkg::CNT_W'(1);
					if (st_reg.cnt == ocs_pkg::CNT_W'(1)) begin
						st_next.xst = ocs_pkg::XS_SYNC;
						st_next.sync_cnt = ocs_pkg::SYNC_CYCLES;
					end
				end
			end
			ocs_pkg::XS_SYNC: begin
				if (rising(st_reg.xck_s)) begin
					st_next.sync_cnt = st_reg.sync_cnt - 2'h1;
					if (st_reg.sync_cnt == 2'h1) begin
						st_next.xst = ocs_pkg::XS_READY;
					end
				end
			end
			ocs_pkg::XS_READY: begin
			end
		endcase
		if (!run_want) begin
			st_next.xst = ocs_pkg::XS_OFF;
		end

		// status: bit 0 local, bits 11:1 from synchronised sources
		status_now = {st_reg.src_s2, st_reg.xst == ocs_pkg::XS_READY};
		st_next.status = status_now;
		rise = status_now & ~st_reg.status;
		// set beats a clear in the same cycle
		st_next.flags = st_reg.flags;
		if (wr && paddr == ocs_pkg::ADDR_IFLAG) begin
			st_next.flags = st_reg.flags & ~pwdata[ocs_pkg::ST_WIDTH-1:0];
		end
		st_next.flags = st_next.flags | rise;
		st_next.irq = |(st_next.flags & st_reg.ien);

		st_next.ready = acc_done;
		st_next.slverr = 1'b0;
		st_next.rdata = 32'h0000_0000;
		if (acc_done && !pwrite) begin
			unique case (paddr)
				ocs_pkg::ADDR_STATUS: st_next.rdata = {20'h0_0000, st_reg.status};
				ocs_pkg::ADDR_XCTRL: st_next.rdata = {16'h0000, st_reg.xctrl};
				ocs_pkg::ADDR_IFLAG: st_next.rdata = {20'h0_0000, st_reg.flags};
				ocs_pkg::ADDR_IEN: st_next.rdata = {20'h0_0000, st_reg.ien};
				default: st_next.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '0;
			st_reg.xctrl <= ocs_pkg::XCTRL_RESET;
			st_reg.xst <= ocs_pkg::XS_OFF;
			// reset control word has the pad bit clear, so the output pad is free
			st_reg.pad_free <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata = st_reg.rdata;
	assign pready = st_reg.ready;
	assign pslverr = st_reg.slverr;
	assign crystal_osc_control_run = st_reg.run;
	assign crystal_osc_control_crystal_mode = st_reg.crystal_mode;
	assign crystal_output_pad_gpio_free = st_reg.pad_free;
	assign crystal_osc_control_auto_gain = st_reg.auto_gain;
	assign crystal_osc_control_gain = st_reg.gain_eff;
	assign irq = st_reg.irq;
endmodule
